// ### idr_pkg.sv
// idr_pkg: constants for the identify device responder
// Functional notes
// - command code ECh starts identification, answered by programmed-I/O data-in reads.
// - set busy, prepare 256 words, then set data request, clear busy, interrupt.
// - busy stays set for as long as media preparation lasts.
// - reserved bits and reserved words return zero.
// - fixed fields change only on media change; variable fields follow state.
// - bit-group words put bit n on host data line n.
// - sixteen bit values put msb on line 15, lsb on line 0.
// - 32-bit values send bits 15..0 first, then bits 31..16.
// - strings put first character on lines 15..8, second on 7..0.
// - word 0 holds class bit 15, removable bit 7, non-removable bit 6.
// - words 1, 3, 6 hold cylinders, heads, sectors per track.
// - serial in words 10-19, firmware in 23-26, model in 27-46.
// - word 22 holds count of extra long-command bytes per sector.
// - word 47 low byte is max sectors per interrupt, high byte vendor.
// - word 0 bits 14..8 and 5..1 vendor, bit 0 reads zero.
`default_nettype none
package idr_pkg;
    localparam logic [7:0] IDR_CMD_IDENTIFY = 8'hEC;
    localparam int IDR_WORDS = 256;
    localparam int IDR_PTR_W = 8;
    localparam logic [7:0] IDR_LAST_WORD = 8'hFF;
    localparam logic [7:0] IDR_W_CONFIG = 8'h00;
    localparam logic [7:0] IDR_W_CYL = 8'h01;
    localparam logic [7:0] IDR_W_HEADS = 8'h03;
    localparam logic [7:0] IDR_W_SPT = 8'h06;
    localparam logic [7:0] IDR_W_SERIAL_LO = 8'h0A;
    localparam logic [7:0] IDR_W_SERIAL_HI = 8'h13;
    localparam logic [7:0] IDR_W_LONG_BYTES = 8'h16;
    localparam logic [7:0] IDR_W_FW_LO = 8'h17;
    localparam logic [7:0] IDR_W_FW_HI = 8'h1A;
    localparam logic [7:0] IDR_W_MODEL_LO = 8'h1B;
    localparam logic [7:0] IDR_W_MODEL_HI = 8'h2E;
    localparam logic [7:0] IDR_W_MULTI = 8'h2F;
    localparam int IDR_BIT_CLASS = 15;
    localparam int IDR_BIT_REMOVABLE = 7;
    localparam int IDR_BIT_FIXED = 6;
    localparam int IDR_SERIAL_CHARS = 20;
    localparam int IDR_FW_CHARS = 8;
    localparam int IDR_MODEL_CHARS = 40;
    localparam logic [15:0] IDR_ZERO_WORD = 16'h0000;
    localparam logic [6:0] IDR_VEND_HI_MASK = 7'h7F;
    localparam logic [4:0] IDR_VEND_LO_MASK = 5'h1F;
    typedef enum logic [1:0] {
        IDR_IDLE = 2'b00,
        IDR_PREP = 2'b01,
        IDR_XFER = 2'b10
    } idr_state_e;
endpackage : idr_pkg
`default_nettype wire

// ### idr_string_word.sv
// idr_string_word: picks one 16-bit word out of a packed ascii string
`default_nettype none
module idr_string_word #(
    parameter int CHARS = 20
) (
    input wire logic [CHARS*8-1:0] str_i,
    input wire logic [7:0] index_i,
    output logic [15:0] word_o
);
    // str_i holds first character in its top byte
    localparam int WORDS = CHARS / 2;
    logic [15:0] words [WORDS];
    genvar g;
    generate
        for (g = 0; g < WORDS; g++) begin : g_w
            assign words[g] = str_i[CHARS*8-1-16*g -: 16];
        end
    endgenerate
    always_comb begin
        word_o = 16'h0000;
        for (int i = 0; i < WORDS; i++) begin
            if (index_i == 8'(i)) begin
                word_o = words[i];
            end
        end
    end
endmodule : idr_string_word
`default_nettype wire

// ### idr_word_mux.sv
// idr_word_mux: forms the parameter word at a given index
`default_nettype none
module idr_word_mux #(
    parameter int SER_CHARS = 20,
    parameter int FW_CHARS = 8,
    parameter int MOD_CHARS = 40
) (
    input wire logic [7:0] ptr_i,
    input wire logic packet_class_i,
    input wire logic removable_i,
    input wire logic fixed_dev_i,
    input wire logic [6:0] vend_hi_i,
    input wire logic [4:0] vend_lo_i,
    input wire logic [15:0] cylinders_i,
    input wire logic [15:0] heads_i,
    input wire logic [15:0] spt_i,
    input wire logic [SER_CHARS*8-1:0] serial_i,
    input wire logic [15:0] long_bytes_i,
    input wire logic [FW_CHARS*8-1:0] firmware_i,
    input wire logic [MOD_CHARS*8-1:0] model_i,
    input wire logic [7:0] multi_vendor_i,
    input wire logic [7:0] multi_max_i,
    output logic [15:0] word_o
);
    logic [15:0] ser_w;
    logic [15:0] fw_w;
    logic [15:0] mod_w;
    idr_string_word #(.CHARS(SER_CHARS)) u_ser (
        .str_i(serial_i),
        .index_i(8'(ptr_i - idr_pkg::IDR_W_SERIAL_LO)),
        .word_o(ser_w)
    );
    idr_string_word #(.CHARS(FW_CHARS)) u_fw (
        .str_i(firmware_i),
        .index_i(8'(ptr_i - idr_pkg::IDR_W_FW_LO)),
        .word_o(fw_w)
    );
    idr_string_word #(.CHARS(MOD_CHARS)) u_mod (
        .str_i(model_i),
        .index_i(8'(ptr_i - idr_pkg::IDR_W_MODEL_LO)),
        .word_o(mod_w)
    );
    always_comb begin
        word_o = idr_pkg::IDR_ZERO_WORD;
        if (ptr_i == idr_pkg::IDR_W_CONFIG) begin
            word_o[idr_pkg::IDR_BIT_CLASS] = packet_class_i;
            word_o[14:8] = vend_hi_i & idr_pkg::IDR_VEND_HI_MASK;
            word_o[idr_pkg::IDR_BIT_REMOVABLE] = removable_i;
            word_o[idr_pkg::IDR_BIT_FIXED] = fixed_dev_i;
            word_o[5:1] = vend_lo_i & idr_pkg::IDR_VEND_LO_MASK;
            word_o[0] = 1'b0;
        end else if (ptr_i == idr_pkg::IDR_W_CYL) begin
            word_o = cylinders_i;
        end else if (ptr_i == idr_pkg::IDR_W_HEADS) begin
            word_o = heads_i;
        end else if (ptr_i == idr_pkg::IDR_W_SPT) begin
            word_o = spt_i;
        end else if (ptr_i >= idr_pkg::IDR_W_SERIAL_LO && ptr_i <= idr_pkg::IDR_W_SERIAL_HI) begin
            word_o = ser_w;
        end else if (ptr_i == idr_pkg::IDR_W_LONG_BYTES) begin
            word_o = long_bytes_i;
        end else if (ptr_i >= idr_pkg::IDR_W_FW_LO && ptr_i <= idr_pkg::IDR_W_FW_HI) begin
            word_o = fw_w;
        end else if (ptr_i >= idr_pkg::IDR_W_MODEL_LO && ptr_i <= idr_pkg::IDR_W_MODEL_HI) begin
            word_o = mod_w;
        end else if (ptr_i == idr_pkg::IDR_W_MULTI) begin
            word_o = {multi_vendor_i, multi_max_i};
        end
    end
endmodule : idr_word_mux
`default_nettype wire

// ### idr_responder.sv
// idr_responder: identify command sequencer and data-register word source
`default_nettype none
module idr_responder #(
    parameter int SER_CHARS = 20,
    parameter int FW_CHARS = 8,
    parameter int MOD_CHARS = 40
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // ****************************************
    // command and host read strobes, media ready and media change
    // ****************************************
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_i,
    input wire logic data_rd_i,
    input wire logic media_ready_i,
    input wire logic media_changed_i,
    // ****************************************
    // identification contents
    // ****************************************
    input wire logic packet_class_i,
    input wire logic removable_i,
    input wire logic fixed_dev_i,
    input wire logic [6:0] vend_hi_i,
    input wire logic [4:0] vend_lo_i,
    input wire logic [15:0] cylinders_i,
    input wire logic [15:0] heads_i,
    input wire logic [15:0] spt_i,
    input wire logic [SER_CHARS*8-1:0] serial_i,
    input wire logic [15:0] long_bytes_i,
    input wire logic [FW_CHARS*8-1:0] firmware_i,
    input wire logic [MOD_CHARS*8-1:0] model_i,
    input wire logic [7:0] multi_vendor_i,
    input wire logic [7:0] multi_max_i,
    // ****************************************
    // status and data toward the host
    // ****************************************
    output logic busy_status_bit_o,
    output logic data_request_bit_o,
    output logic drive_ready_bit_o,
    output logic intrq_o,
    output logic [15:0] host_data_bus_o
);
    idr_pkg::idr_state_e state_q, state_d;
    logic [7:0] ptr_q, ptr_d;
    logic [15:0] data_q, data_d;
    logic irq_q, irq_d;
    logic [15:0] word_w;
    logic [7:0] mux_ptr;

    // ****************************************
    // word source
    // ****************************************
    // the next word is fetched ahead so the data register always holds the current one
    idr_word_mux #(.SER_CHARS(SER_CHARS), .FW_CHARS(FW_CHARS), .MOD_CHARS(MOD_CHARS)) u_mux (
        .ptr_i(mux_ptr),
        .packet_class_i(packet_class_i),
        .removable_i(removable_i),
        .fixed_dev_i(fixed_dev_i),
        .vend_hi_i(vend_hi_i),
        .vend_lo_i(vend_lo_i),
        .cylinders_i(cylinders_i),
        .heads_i(heads_i),
        .spt_i(spt_i),
        .serial_i(serial_i),
        .long_bytes_i(long_bytes_i),
        .firmware_i(firmware_i),
        .model_i(model_i),
        .multi_vendor_i(multi_vendor_i),
        .multi_max_i(multi_max_i),
        .word_o(word_w)
    );

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        ptr_d = ptr_q;
        data_d = data_q;
        irq_d = irq_q;
        mux_ptr = ptr_q;
        unique case (state_q)
            idr_pkg::IDR_IDLE: begin
                // other opcodes belong to other logic and are ignored here
                if (cmd_wr_i && cmd_i == idr_pkg::IDR_CMD_IDENTIFY) begin
                    state_d = idr_pkg::IDR_PREP;
                    ptr_d = 8'h00;
                    irq_d = 1'b0;
                end
            end
            idr_pkg::IDR_PREP: begin
                // word 0 is sampled once media is ready; later words are taken from the inputs as each read advances
                mux_ptr = 8'h00;
                if (media_ready_i) begin
                    data_d = word_w;
                    state_d = idr_pkg::IDR_XFER;
                    irq_d = 1'b1;
                end
            end
            idr_pkg::IDR_XFER: begin
                mux_ptr = 8'(ptr_q + 8'h01);
                if (data_rd_i) begin
                    irq_d = 1'b0;
                    ptr_d = 8'(ptr_q + 8'h01);
                    data_d = word_w;
                    if (ptr_q == idr_pkg::IDR_LAST_WORD) begin
                        state_d = idr_pkg::IDR_IDLE;
                        data_d = idr_pkg::IDR_ZERO_WORD;
                    end
                end
            end
            default: begin
                state_d = idr_pkg::IDR_IDLE;
            end
        endcase
        if (media_changed_i && state_q == idr_pkg::IDR_IDLE) begin
            irq_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= idr_pkg::IDR_IDLE;
            ptr_q <= 8'h00;
            data_q <= 16'h0000;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ptr_q <= ptr_d;
            data_q <= data_d;
            irq_q <= irq_d;
        end
    end

    // ****************************************
    // status
    // ****************************************
    assign busy_status_bit_o = (state_q == idr_pkg::IDR_PREP);
    assign data_request_bit_o = (state_q == idr_pkg::IDR_XFER);
    assign drive_ready_bit_o = (state_q != idr_pkg::IDR_PREP);
    assign intrq_o = irq_q;
    assign host_data_bus_o = data_q;
endmodule : idr_responder
`default_nettype wire

// ### idr_responder_properties.sv
// idr_responder_properties: port-level checks of the identify responder
`default_nettype none
module idr_responder_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_i,
    input wire logic data_rd_i,
    input wire logic media_ready_i,
    input wire logic packet_class_i,
    input wire logic removable_i,
    input wire logic fixed_dev_i,
    input wire logic [6:0] vend_hi_i,
    input wire logic [4:0] vend_lo_i,
    input wire logic busy_status_bit_o,
    input wire logic data_request_bit_o,
    input wire logic drive_ready_bit_o,
    input wire logic intrq_o,
    input wire logic [15:0] host_data_bus_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire idle = !busy_status_bit_o && !data_request_bit_o;
    a_cmd_busy: assert property (idle && cmd_wr_i && cmd_i == idr_pkg::IDR_CMD_IDENTIFY
        |=> busy_status_bit_o && !drive_ready_bit_o) else $error("identify not taken");
    a_other_cmd: assert property (idle && cmd_wr_i && cmd_i != idr_pkg::IDR_CMD_IDENTIFY |=> idle)
        else $error("foreign command taken");
    a_busy_hold: assert property (busy_status_bit_o && !media_ready_i |=> busy_status_bit_o)
        else $error("busy dropped early");
    a_ready_seq: assert property (busy_status_bit_o && media_ready_i
        |=> !busy_status_bit_o && data_request_bit_o && intrq_o) else $error("ready sequence wrong");
    a_word_zero: assert property ($rose(data_request_bit_o) |-> host_data_bus_o ==
        {packet_class_i, vend_hi_i, removable_i, fixed_dev_i, vend_lo_i, 1'b0}) else $error("word 0 wrong");
    a_intrq_clear: assert property (intrq_o && data_rd_i |=> !intrq_o)
        else $error("interrupt not cleared by read");
    a_word_stands: assert property (data_request_bit_o && !data_rd_i |=> $stable(host_data_bus_o))
        else $error("word moved without read");
    a_end_zero: assert property ($fell(data_request_bit_o) |-> idle && host_data_bus_o == 16'h0000)
        else $error("end of transfer not idle");
endmodule : idr_responder_properties
bind idr_responder idr_responder_properties u_props (.clk_i, .rst_i, .cmd_wr_i, .cmd_i, .data_rd_i,
    .media_ready_i, .packet_class_i, .removable_i, .fixed_dev_i, .vend_hi_i, .vend_lo_i, .busy_status_bit_o,
    .data_request_bit_o, .drive_ready_bit_o, .intrq_o, .host_data_bus_o);
`default_nettype wire

// ### idr_host.sv
// idr_host: host adapter model issuing commands and data-register reads
`default_nettype none
module idr_host (
    input wire logic clk_i,
    input wire logic drive_ready_i,
    output logic cmd_wr_o,
    output logic [7:0] cmd_o,
    output logic data_rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_wr_o = 1'b0;
        cmd_o = 8'h00;
        data_rd_o = 1'b0;
    end
    task automatic poke_cmd(input logic on, input logic [7:0] code);
        cmd_wr_o = on;
        cmd_o = on ? code : ~code; // released byte scrambled, never held
    endtask : poke_cmd
    task automatic send_cmd(input logic [7:0] code);
        @(negedge clk_i);
        while (drive_ready_i !== 1'b1) @(negedge clk_i);
        poke_cmd(1'b1, code);
        @(negedge clk_i);
        poke_cmd(1'b0, code);
    endtask : send_cmd
    task automatic set_read(input logic on);
        data_rd_o = on;
    endtask : set_read
endmodule : idr_host
`default_nettype wire

// ### tb_top.sv
// tb_top: randomized identify runs against the responder through a host model
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic media_ready_i = 1'b0;
    logic pc, rm, fx, cmd_wr, data_rd, busy, data_request_bit, rdy, irq, chg;
    logic [6:0] vh;
    logic [4:0] vl;
    logic [7:0] mv, mm, cmd;
    logic [15:0] cyl, hd, spt, lb, data;
    logic [159:0] ser;
    logic [63:0] fw;
    logic [319:0] mdl;
    logic [31:0] st = 32'hEEDD;
    int failures = 0;
    int compares = 0;
    initial forever #5 clk_i = ~clk_i;
    idr_host host (.clk_i(clk_i), .drive_ready_i(rdy), .cmd_wr_o(cmd_wr), .cmd_o(cmd), .data_rd_o(data_rd));
    idr_responder uut (.clk_i(clk_i), .rst_i(rst_i), .cmd_wr_i(cmd_wr), .cmd_i(cmd), .data_rd_i(data_rd),
        .media_ready_i(media_ready_i), .media_changed_i(chg), .packet_class_i(pc), .removable_i(rm),
        .fixed_dev_i(fx), .vend_hi_i(vh), .vend_lo_i(vl), .cylinders_i(cyl), .heads_i(hd), .spt_i(spt),
        .serial_i(ser), .long_bytes_i(lb), .firmware_i(fw), .model_i(mdl), .multi_vendor_i(mv),
        .multi_max_i(mm), .busy_status_bit_o(busy), .data_request_bit_o(data_request_bit), .drive_ready_bit_o(rdy),
        .intrq_o(irq), .host_data_bus_o(data));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic shuffle();
        for (int i = 0; i < 40; i++) begin
            st = nxt(st);
            mdl[i*8+:8] = st[7:0];
            if (i < 20) ser[i*8+:8] = st[15:8];
            if (i < 8) fw[i*8+:8] = st[23:16];
            if (i == 9) {pc, rm, fx, vh, vl, mv} = st[22:0];
            if (i == 19) {cyl, hd} = st;
            if (i == 29) {spt, lb} = st;
        end
        mm = st[7:0];
    endtask : shuffle
    function automatic logic [15:0] exp_word(input int n);
        if (n == 0) return {pc, vh, rm, fx, vl, 1'b0};
        if (n == 1) return cyl;
        if (n == 3) return hd;
        if (n == 6) return spt;
        if (n == 22) return lb;
        if (n == 47) return {mv, mm};
        if (n >= 10 && n <= 19) return ser[(19 - n) * 16 +: 16];
        if (n >= 23 && n <= 26) return fw[(26 - n) * 16 +: 16];
        if (n >= 27 && n <= 46) return mdl[(46 - n) * 16 +: 16];
        return 16'h0000;
    endfunction : exp_word
    task automatic chk_w(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk_w
    task automatic chk_b(input string what, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask : chk_b
    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
    initial begin
        chg = 1'b0;
        shuffle();
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        chk_b("ready", 1'b1, rdy);
        chk_w("idle data", 16'h0000, data);
        host.set_read(1'b1);
        @(negedge clk_i);
        host.set_read(1'b0);
        host.send_cmd(8'hA1);
        chk_b("busy", 1'b0, busy);
        // a media change while idle must not start anything
        chg = 1'b1;
        @(negedge clk_i);
        chg = 1'b0;
        chk_b("idle intrq", 1'b0, irq);
        chk_b("idle busy", 1'b0, busy);
        $display("idle checks done");
        for (int r = 0; r < 3; r++) begin
            shuffle();
            mm = (r == 0) ? 8'h01 : (r == 1) ? 8'hFF : mm;
            host.send_cmd(idr_pkg::IDR_CMD_IDENTIFY);
            for (int k = 0; k <= st[2:0]; k++) begin
                chk_b("busy", 1'b1, busy);
                @(negedge clk_i);
            end
            media_ready_i = 1'b1;
            @(negedge clk_i);
            media_ready_i = 1'b0;
            chk_b("intrq", 1'b1, irq);
            // media change outside idle leaves a pending interrupt alone
            chg = 1'b1;
            @(negedge clk_i);
            chg = 1'b0;
            chk_b("intrq held", 1'b1, irq);
            for (int n = 0; n < 256; n++) begin
                chk_w("word", exp_word(n), data);
                if (n == 1) chk_b("intrq", 1'b0, irq);
                if (r == 2 && n[0]) begin
                    host.set_read(1'b0);
                    @(negedge clk_i);
                end
                host.set_read(1'b1);
                host.poke_cmd(r == 1 && n == 100, idr_pkg::IDR_CMD_IDENTIFY);
                // media ready toggles at random during the transfer and must be ignored
                media_ready_i = st[n[4:0]];
                @(negedge clk_i);
            end
            host.set_read(1'b0);
            media_ready_i = 1'b0;
            chk_b("drq", 1'b0, data_request_bit);
            chk_w("end data", 16'h0000, data);
            $display("run %0d done", r);
        end
        // reset in the middle of a transfer, then a fresh request restarts at word 0
        host.send_cmd(idr_pkg::IDR_CMD_IDENTIFY);
        media_ready_i = 1'b1;
        @(negedge clk_i);
        media_ready_i = 1'b0;
        host.set_read(1'b1);
        @(negedge clk_i);
        host.set_read(1'b0);
        chk_w("word 1", exp_word(1), data);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        chk_b("reset drq", 1'b0, data_request_bit);
        chk_b("reset busy", 1'b0, busy);
        chk_b("reset ready", 1'b1, rdy);
        chk_b("reset intrq", 1'b0, irq);
        chk_w("reset data", 16'h0000, data);
        host.send_cmd(idr_pkg::IDR_CMD_IDENTIFY);
        chk_b("restart busy", 1'b1, busy);
        media_ready_i = 1'b1;
        @(negedge clk_i);
        media_ready_i = 1'b0;
        chk_w("restart word", exp_word(0), data);
        $display("reset run done");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
